/* include/dyn_sizer_map.svh */
// constant map of the dynamic bus sizer: codes and lane indices
`ifndef DYN_SIZER_MAP_SVH
`define DYN_SIZER_MAP_SVH

// acknowledge codes as {periph_ack_hi, periph_ack_lo} pin levels
`define DBS_ACK_WAIT  2'h3
`define DBS_ACK_8     2'h2
`define DBS_ACK_16    2'h1
`define DBS_ACK_32    2'h0

// access size codes as {access_size_hi, access_size_lo}
`define DBS_SIZ_BYTE  2'h1
`define DBS_SIZ_WORD  2'h2

// byte indices, 0 is the most significant lane
`define DBS_IDX_FIRST 2'h0
`define DBS_IDX_HALF2 2'h2
`define DBS_IDX_LAST  2'h3
`define DBS_IDX_STEP  2'h1

`endif

/* include/dyn_sizer_pkg.sv */
// types shared by the dynamic bus sizer
`default_nettype none

package dyn_sizer_pkg;

    // ====================================================================
    // access sequencer states
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_XFER = 5'b00010,
        ST_NEXT = 5'b00100,
        ST_DONE = 5'b01000,
        ST_HOLD = 5'b10000
    } state_e;

    // word seen as four bytes, element 0 is bits 31:24
    typedef logic [0:3][7:0] word_bytes_t;

    // all pin inputs, carried together through the synchroniser
    typedef struct packed {
        logic        cs_n;
        logic        rd;
        logic [1:0]  siz;
        logic [1:0]  ofs;
        logic [1:0]  ack;
        logic [31:0] cpu_data;
        logic [15:0] periph_data;
    } pin_in_s;

endpackage : dyn_sizer_pkg

`default_nettype wire

/* hdl/in_sync.sv */
// three-stage pin synchroniser with agreement filter
`default_nettype none

module in_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    // raw and filtered levels
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] out_r;
    logic [WIDTH-1:0] out_nxt;

    // a bit changes only once stages two and three agree
    assign out_nxt = (s2_r & ~(s2_r ^ s3_r)) | (out_r & (s2_r ^ s3_r));
    assign sync_o  = out_r;

    // resets to all ones: pins read as negated and idle
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s1_r  <= '1;
            s2_r  <= '1;
            s3_r  <= '1;
            out_r <= '1;
        end else begin
            s1_r  <= async_i;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            out_r <= out_nxt;
        end
    end

endmodule : in_sync

`default_nettype wire

/* hdl/dynamic_bus_sizer.sv */
// dynamic bus sizer: 32-bit processor bus to 8/16/32-bit peripheral port
`include "dyn_sizer_map.svh"
`default_nettype none

module dynamic_bus_sizer (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        reset_n_i,
    // processor bus control
    input  wire logic        chip_sel_n_i,
    input  wire logic        read_write_i,
    input  wire logic        access_size_hi_i,
    input  wire logic        access_size_lo_i,
    input  wire logic        byte_offset_hi_i,
    input  wire logic        byte_offset_lo_i,
    output logic             cpu_xfer_ack_n_o,
    // processor data, bit i of the enable covers bits 8i+7:8i
    input  wire logic [31:0] cpu_data_i,
    output logic      [31:0] cpu_data_o,
    output logic      [3:0]  cpu_data_oe_n_o,
    // peripheral control
    output logic             periph_byte_addr_hi_o,
    output logic             periph_byte_addr_lo_o,
    output logic             periph_strobe_n_o,
    output logic             upper_lane_write_en_n_o,
    output logic             lower_lane_write_en_n_o,
    output logic             byte_port_write_en_n_o,
    input  wire logic        periph_ack_hi_n_i,
    input  wire logic        periph_ack_lo_n_i,
    // peripheral data, upper half
    input  wire logic [15:0] periph_data_upper_i,
    output logic      [15:0] periph_data_upper_o,
    output logic             periph_data_upper_oe_n_o
);

    // ====================================================================
    // pin synchronisers
    dyn_sizer_pkg::pin_in_s pins_raw;
    dyn_sizer_pkg::pin_in_s pins;

    assign pins_raw = {chip_sel_n_i, read_write_i,
                       access_size_hi_i, access_size_lo_i,
                       byte_offset_hi_i, byte_offset_lo_i,
                       periph_ack_hi_n_i, periph_ack_lo_n_i,
                       cpu_data_i, periph_data_upper_i};

    // every pin is registered before use
    in_sync #(
        .WIDTH ($bits(dyn_sizer_pkg::pin_in_s))
    ) u_sync (
        .clk_i     (ref_clk_i),
        .reset_n_i (reset_n_i),
        .async_i   (pins_raw),
        .sync_o    (pins)
    );

    // ====================================================================
    // state
    dyn_sizer_pkg::state_e      state_r;
    dyn_sizer_pkg::state_e      state_nxt;
    logic [1:0]                 cur_r;
    logic [1:0]                 cur_nxt;
    logic [1:0]                 end_r;
    logic [1:0]                 port_r;
    logic                       rd_r;
    dyn_sizer_pkg::word_bytes_t wdata_r;
    dyn_sizer_pkg::word_bytes_t rdata_r;
    dyn_sizer_pkg::word_bytes_t rdata_nxt;
    logic [1:0]                 addr_r;
    logic                       strobe_n_r;
    logic                       xack_n_r;
    logic                       upper_we_n_r;
    logic                       lower_we_n_r;
    logic                       byte_we_n_r;
    logic [15:0]                pd_out_r;
    logic                       pd_oe_n_r;
    logic [3:0]                 cpu_oe_n_r;

    // ====================================================================
    // decode of access and acknowledge codes
    wire logic        cs_act   = !pins.cs_n;
    wire logic        is_byte  = pins.siz == `DBS_SIZ_BYTE;
    wire logic        is_word  = pins.siz == `DBS_SIZ_WORD;
    wire logic        ack_seen = pins.ack != `DBS_ACK_WAIT;
    wire logic        port8    = pins.ack == `DBS_ACK_8;
    wire logic        port16   = pins.ack == `DBS_ACK_16;
    wire logic        is_idle  = state_r == dyn_sizer_pkg::ST_IDLE;
    wire logic        xfer_ack = state_r == dyn_sizer_pkg::ST_XFER
                                 && cs_act && ack_seen;
    // offset 00 is lane D31:24, long words start on lane 0
    wire logic [1:0]  start_idx = is_byte ? pins.ofs :
                                  is_word ? {pins.ofs[1], 1'b0} :
                                  `DBS_IDX_FIRST;
    wire logic [1:0]  end_idx   = is_byte ? pins.ofs :
                                  is_word ? {pins.ofs[1], 1'b1} :
                                  `DBS_IDX_LAST;
    // narrower ports need more transfers to cover the access
    wire logic        last_xfer = port8  ? (cur_r == end_r) :
                                  port16 ? (cur_r[1] == end_r[1]) : 1'b1;
    wire logic [1:0]  cur_step  = (port_r == `DBS_ACK_8) ?
                                  cur_r + `DBS_IDX_STEP : `DBS_IDX_HALF2;
    wire logic [1:0]  port_nxt  = xfer_ack ? pins.ack : port_r;
    // values as they stand once the next state is entered
    wire logic        rd_nxt    = is_idle ? pins.rd : rd_r;
    wire logic [1:0]  end_nxt   = is_idle ? end_idx : end_r;
    wire dyn_sizer_pkg::word_bytes_t wsrc =
        is_idle ? dyn_sizer_pkg::word_bytes_t'(pins.cpu_data) : wdata_r;
    wire logic        xfer_nxt  = state_nxt == dyn_sizer_pkg::ST_XFER;
    wire logic        wr_xfer   = xfer_nxt && !rd_nxt;
    wire logic        rd_out    = rd_nxt
                                  && (state_nxt == dyn_sizer_pkg::ST_DONE
                                  || state_nxt == dyn_sizer_pkg::ST_HOLD);
    // odd bytes go on both lanes so 8 and 16-bit ports both see them
    wire logic [7:0]  pd_hi_nxt = wsrc[cur_nxt];
    wire logic [7:0]  pd_lo_nxt = cur_nxt[0] ? wsrc[cur_nxt]
                                  : wsrc[{cur_nxt[1], 1'b1}];

    // sequencer: strobe, wait on HH, step, acknowledge, wait for release
    always_comb begin
        state_nxt = state_r;
        cur_nxt   = cur_r;
        case (state_r)
            dyn_sizer_pkg::ST_IDLE: begin
                if (cs_act) begin
                    state_nxt = dyn_sizer_pkg::ST_XFER;
                    cur_nxt   = start_idx;
                end
            end
            dyn_sizer_pkg::ST_XFER: begin
                if (!cs_act) begin
                    state_nxt = dyn_sizer_pkg::ST_IDLE;
                end else if (ack_seen) begin
                    state_nxt = last_xfer ? dyn_sizer_pkg::ST_DONE
                                          : dyn_sizer_pkg::ST_NEXT;
                end
            end
            dyn_sizer_pkg::ST_NEXT: begin
                // next strobe only after the peripheral drops its code
                if (!cs_act) begin
                    state_nxt = dyn_sizer_pkg::ST_IDLE;
                end else if (!ack_seen) begin
                    state_nxt = dyn_sizer_pkg::ST_XFER;
                    cur_nxt   = cur_step;
                end
            end
            dyn_sizer_pkg::ST_DONE: begin
                state_nxt = cs_act ? dyn_sizer_pkg::ST_HOLD
                                   : dyn_sizer_pkg::ST_IDLE;
            end
            dyn_sizer_pkg::ST_HOLD: begin
                if (!cs_act) begin
                    state_nxt = dyn_sizer_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = dyn_sizer_pkg::ST_IDLE;
            end
        endcase
    end

    // read lanes: earlier bytes stay latched until the access ends
    always_comb begin
        rdata_nxt = rdata_r;
        if (xfer_ack && rd_r) begin
            if (port8) begin
                rdata_nxt[cur_r] = pins.periph_data[15:8];
            end else if (port16) begin
                rdata_nxt[{cur_r[1], 1'b0}] = pins.periph_data[15:8];
                rdata_nxt[{cur_r[1], 1'b1}] = pins.periph_data[7:0];
            end else begin
                rdata_nxt[0] = pins.periph_data[15:8];
                rdata_nxt[1] = pins.periph_data[7:0];
            end
        end
    end

    // ====================================================================
    // access registers
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= dyn_sizer_pkg::ST_IDLE;
            cur_r   <= `DBS_IDX_FIRST;
            end_r   <= `DBS_IDX_FIRST;
            port_r  <= `DBS_ACK_32;
            rd_r    <= 1'b1;
            wdata_r <= '0;
            rdata_r <= '0;
        end else begin
            state_r <= state_nxt;
            cur_r   <= cur_nxt;
            end_r   <= end_nxt;
            port_r  <= port_nxt;
            rd_r    <= rd_nxt;
            wdata_r <= wsrc;
            rdata_r <= rdata_nxt;
        end
    end

    // output registers, loaded from the next state so pins move together
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            addr_r       <= `DBS_IDX_FIRST;
            strobe_n_r   <= 1'b1;
            xack_n_r     <= 1'b1;
            upper_we_n_r <= 1'b1;
            lower_we_n_r <= 1'b1;
            byte_we_n_r  <= 1'b1;
            pd_out_r     <= '0;
            pd_oe_n_r    <= 1'b1;
            cpu_oe_n_r   <= 4'hf;
        end else begin
            addr_r       <= cur_nxt;
            strobe_n_r   <= !xfer_nxt;
            xack_n_r     <= state_nxt != dyn_sizer_pkg::ST_DONE;
            upper_we_n_r <= !(wr_xfer && !cur_nxt[0]);
            lower_we_n_r <= !(wr_xfer
                            && (cur_nxt[0] || cur_nxt != end_nxt));
            byte_we_n_r  <= !wr_xfer;
            pd_out_r     <= {pd_hi_nxt, pd_lo_nxt};
            pd_oe_n_r    <= !wr_xfer;
            cpu_oe_n_r[3:2] <= {2{!rd_out}};
            // on 32-bit ports the outside transceivers own D15-D0
            cpu_oe_n_r[1:0] <= {2{!(rd_out && port_nxt != `DBS_ACK_32)}};
        end
    end

    assign cpu_data_o               = rdata_r;
    assign cpu_data_oe_n_o          = cpu_oe_n_r;
    assign cpu_xfer_ack_n_o         = xack_n_r;
    assign periph_byte_addr_hi_o    = addr_r[1];
    assign periph_byte_addr_lo_o    = addr_r[0];
    assign periph_strobe_n_o        = strobe_n_r;
    assign upper_lane_write_en_n_o  = upper_we_n_r;
    assign lower_lane_write_en_n_o  = lower_we_n_r;
    assign byte_port_write_en_n_o   = byte_we_n_r;
    assign periph_data_upper_o      = pd_out_r;
    assign periph_data_upper_oe_n_o = pd_oe_n_r;

    // ====================================================================
    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    property p_start;
        is_idle && cs_act |=> !strobe_n_r && state_r == dyn_sizer_pkg::ST_XFER;
    endproperty
    a_start: assert property (p_start)
        else $error("chip select did not start a transfer");

    property p_xack_one;
        !xack_n_r |=> xack_n_r;
    endproperty
    a_xack_one: assert property (p_xack_one)
        else $error("transfer acknowledge longer than one clock");

    property p_xack_cause;
        !xack_n_r |-> $past(xfer_ack);
    endproperty
    a_xack_cause: assert property (p_xack_cause)
        else $error("acknowledge without peripheral acknowledge");

    property p_release;
        !cs_act |=> is_idle && strobe_n_r && xack_n_r;
    endproperty
    a_release: assert property (p_release)
        else $error("no return to idle after chip select release");

    property p_wait;
        state_r == dyn_sizer_pkg::ST_XFER && cs_act && !ack_seen
        |=> state_r == dyn_sizer_pkg::ST_XFER && $stable(addr_r);
    endproperty
    a_wait: assert property (p_wait)
        else $error("wait code did not hold the transfer");

    property p_low_z;
        state_r == dyn_sizer_pkg::ST_XFER || state_r == dyn_sizer_pkg::ST_NEXT
        |-> cpu_oe_n_r[1:0] == 2'h3;
    endproperty
    a_low_z: assert property (p_low_z)
        else $error("low processor lanes driven before width known");

    property p_step8;
        state_r == dyn_sizer_pkg::ST_NEXT && port_r == `DBS_ACK_8
        && cs_act && !ack_seen |=> addr_r == $past(cur_r) + 2'h1;
    endproperty
    a_step8: assert property (p_step8)
        else $error("byte address did not step on 8-bit port");

    property p_swe;
        !strobe_n_r && !rd_r |-> !byte_we_n_r && pd_oe_n_r == 1'b0;
    endproperty
    a_swe: assert property (p_swe)
        else $error("write strobe without byte write enable");

    property p_rd_no_we;
        !strobe_n_r && rd_r
        |-> byte_we_n_r && upper_we_n_r && lower_we_n_r && pd_oe_n_r;
    endproperty
    a_rd_no_we: assert property (p_rd_no_we)
        else $error("write enable or drive during a read transfer");

endmodule : dynamic_bus_sizer

`default_nettype wire

/* sim/periph_model.sv */
// peripheral port model: answers each strobe with a sized acknowledge
`default_nettype none

module periph_model (
    // clock
    input  wire logic        clk_i,
    // set-up from the bench
    input  wire logic [1:0]  width_code_i,
    input  wire logic [7:0]  waits_i,
    // peripheral bus
    input  wire logic        strobe_n_i,
    input  wire logic        addr_hi_i,
    input  wire logic        addr_lo_i,
    input  wire logic        upper_we_n_i,
    input  wire logic        lower_we_n_i,
    input  wire logic        byte_we_n_i,
    input  wire logic [15:0] data_i,
    output logic             ack_hi_n_o,
    output logic             ack_lo_n_o,
    output logic      [15:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mem [0:3];
    logic [1:0] a;
    logic [1:0] ev;
    logic [1:0] od;
    int         cnt = 0;

    // lane selection; a wide port only sees the upper half here
    assign a  = {addr_hi_i, addr_lo_i};
    assign ev = {a[1], 1'b0};
    assign od = {a[1], 1'b1};

    initial begin
        {ack_hi_n_o, ack_lo_n_o} = 2'h3;
        data_o = 16'h0;
    end

    // ===============================================================
    // transfer answer: waits, then width code until strobe goes high
    always @(posedge clk_i) begin
        if (strobe_n_i) begin
            cnt <= 0;
            {ack_hi_n_o, ack_lo_n_o} <= 2'h3;
            data_o <= ~data_o;
        end else if ({ack_hi_n_o, ack_lo_n_o} == 2'h3) begin
            if (cnt < int'(waits_i)) begin
                cnt <= cnt + 1;
                data_o <= ~data_o;
            end else begin
                {ack_hi_n_o, ack_lo_n_o} <= width_code_i;
                if (width_code_i == 2'h2) begin
                    data_o <= {mem[a], ~mem[a]};
                end else begin
                    data_o <= {mem[ev], mem[od]};
                end
                // low transceiver lanes of a wide port are not modelled
                if (width_code_i == 2'h2 && !byte_we_n_i) begin
                    mem[a] <= data_i[15:8];
                end
                if (width_code_i != 2'h2 && !(width_code_i == 2'h0 && a[1])
                    && !upper_we_n_i) begin
                    mem[ev] <= data_i[15:8];
                end
                if (width_code_i != 2'h2 && !(width_code_i == 2'h0 && a[1])
                    && !lower_we_n_i) begin
                    mem[od] <= data_i[7:0];
                end
            end
        end
    end
endmodule : periph_model

`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the dynamic bus sizer
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        cs_n    = 1'b1;
    logic        rw      = 1'b1;
    logic [1:0]  siz     = 2'h0;
    logic [1:0]  ofs     = 2'h0;
    logic [1:0]  pcode   = 2'h0;
    logic [7:0]  waits   = 8'h0;
    logic [31:0] wdata   = 32'h0;
    logic [31:0] lfsr    = 32'h16d2;
    logic [31:0] rdata;
    logic [3:0]  oe_n;
    logic        xfer_ack_n, addr_hi, addr_lo, strobe_n;
    logic        upper_we_n, lower_we_n, byte_we_n, ack_hi_n, ack_lo_n;
    logic        pd_oe_n;
    logic [15:0] pd_in, pd_out;
    int          num_errors = 0;
    int          total_checks = 0;
    // outside low-half transceivers: on only for 32-bit ports, pointing
    // with read/write; the sizer must leave its low lanes alone then
    logic        xcvr_en;
    logic        xcvr_to_cpu;
    logic        lo_clash;
    assign xcvr_en     = !cs_n && pcode == 2'h0;
    assign xcvr_to_cpu = rw;
    assign lo_clash    = xcvr_en && xcvr_to_cpu && oe_n[1:0] != 2'h3;

    initial forever #20 ref_clk = ~ref_clk;

    dynamic_bus_sizer u_dynamic_bus_sizer (
        .ref_clk_i(ref_clk), .reset_n_i(reset_n), .chip_sel_n_i(cs_n),
        .read_write_i(rw), .access_size_hi_i(siz[1]),
        .access_size_lo_i(siz[0]), .byte_offset_hi_i(ofs[1]),
        .byte_offset_lo_i(ofs[0]), .cpu_xfer_ack_n_o(xfer_ack_n),
        .cpu_data_i(wdata), .cpu_data_o(rdata), .cpu_data_oe_n_o(oe_n),
        .periph_byte_addr_hi_o(addr_hi), .periph_byte_addr_lo_o(addr_lo),
        .periph_strobe_n_o(strobe_n), .upper_lane_write_en_n_o(upper_we_n),
        .lower_lane_write_en_n_o(lower_we_n),
        .byte_port_write_en_n_o(byte_we_n), .periph_ack_hi_n_i(ack_hi_n),
        .periph_ack_lo_n_i(ack_lo_n), .periph_data_upper_i(pd_in),
        .periph_data_upper_o(pd_out), .periph_data_upper_oe_n_o(pd_oe_n));

    periph_model u_periph_model (
        .clk_i(ref_clk), .width_code_i(pcode), .waits_i(waits),
        .strobe_n_i(strobe_n), .addr_hi_i(addr_hi), .addr_lo_i(addr_lo),
        .upper_we_n_i(upper_we_n), .lower_we_n_i(lower_we_n),
        .byte_we_n_i(byte_we_n), .data_i(pd_out), .ack_hi_n_o(ack_hi_n),
        .ack_lo_n_o(ack_lo_n), .data_o(pd_in));

    // ===============================================================
    // helpers
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wrap_up;
        if (num_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    // ===============================================================
    // one processor access against the reference byte image
    task automatic access(input logic r, input logic [1:0] s,
                          input logic [1:0] o, input logic [1:0] pc);
        int         n, w, start, step, xfers, got, done;
        logic       prev;
        logic [7:0] em [0:3];
        n = (s == 2'h1) ? 1 : (s == 2'h2) ? 2 : 4;
        start = (n == 4) ? 0 : (n == 2) ? int'({o[1], 1'b0}) : int'(o);
        w = (pc == 2'h2) ? 1 : (pc == 2'h1) ? 2 : 4;
        step = (w == 1) ? 1 : 2;
        xfers = (w == 1) ? n : (w == 2 && n == 4) ? 2 : 1;
        for (int i = 0; i < 4; i++) begin
            lfsr = next_rand(lfsr);
            u_periph_model.mem[i] = lfsr[7:0];
            em[i] = lfsr[7:0];
        end
        lfsr = next_rand(lfsr);
        @(negedge ref_clk);
        {rw, siz, ofs, pcode} = {r, s, o, pc};
        {wdata, waits} = {lfsr, 6'h0, lfsr[1:0]};
        cs_n = 1'b0;
        if (!r) begin
            for (int j = start; j < start + n; j++) begin
                if (!(w == 4 && j >= 2)) em[j] = wdata[31 - 8 * j -: 8];
            end
        end
        got = 0;
        done = 0;
        prev = 1'b1;
        for (int c = 0; c < 400 && done == 0; c++) begin
            @(negedge ref_clk);
            if (prev && !strobe_n) begin
                chk(32'({addr_hi, addr_lo}), 32'(start + got * step));
                got++;
            end
            // peripheral data driven only under a write strobe
            if (!strobe_n) begin
                chk(32'(pd_oe_n), 32'(r));
            end
            chk(32'(lo_clash), 32'h0);
            prev = strobe_n;
            if (xfer_ack_n === 1'b0) done = 1;
        end
        if (done == 0) begin
            num_errors++;
            wrap_up();
        end
        chk(32'(got), 32'(xfers));
        chk(32'(strobe_n), 32'h1);
        chk(32'(oe_n), r ? ((w == 4) ? 32'h3 : 32'h0) : 32'hf);
        for (int j = start; j < start + n; j++) begin
            if (r && !(w == 4 && j >= 2)) begin
                chk(32'(rdata[31 - 8 * j -: 8]), 32'(em[j]));
            end
        end
        @(negedge ref_clk);
        chk(32'(xfer_ack_n), 32'h1);
        for (int i = 0; i < 4; i++) begin
            chk(32'(u_periph_model.mem[i]), 32'(em[i]));
        end
        cs_n = 1'b1;
        for (int c = 0; c < 20 && !(oe_n === 4'hf && strobe_n); c++) begin
            @(negedge ref_clk);
        end
        chk(32'({strobe_n, oe_n}), 32'h1f);
        repeat (8) @(negedge ref_clk);
    endtask : access

    // ===============================================================
    // main sequence: every port width, size code, offset and direction
    initial begin
        repeat (2) @(negedge ref_clk);
        chk(32'({strobe_n, xfer_ack_n, oe_n}), 32'h3f);
        @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        for (int pc = 0; pc < 3; pc++) begin
            for (int s = 0; s < 4; s++) begin
                for (int o = 0; o < 4; o++) begin
                    access(1'b1, 2'(s), 2'(o), 2'(pc));
                    access(1'b0, 2'(s), 2'(o), 2'(pc));
                end
            end
        end
        // release of chip select in the middle of a slow transfer
        waits = 8'h3c;
        {rw, siz, ofs, pcode} = {1'b1, 2'h1, 2'h2, 2'h2};
        cs_n = 1'b0;
        repeat (12) @(negedge ref_clk);
        cs_n = 1'b1;
        for (int c = 0; c < 80; c++) begin
            @(negedge ref_clk);
            chk(32'(xfer_ack_n), 32'h1);
        end
        chk(32'({strobe_n, oe_n}), 32'h1f);
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire
